// ===== pkg/cpt_params.svh
// Purpose: Constants for the capture and PWM timer.
// Assumes: Included by its bare name.
// Notes: Status vector bit positions are listed here too.
`ifndef CPT_PARAMS_SVH
`define CPT_PARAMS_SVH

`define CPT_CFG_32 3'h0
`define CPT_CFG_RTC 3'h1
`define CPT_CFG_16_BIT 2
`define CPT_TMF_ONESHOT 2'h1
`define CPT_TMF_PERIODIC 2'h2
`define CPT_TMF_CAPTURE 2'h3
`define CPT_EV_RISE 2'h0
`define CPT_EV_FALL 2'h1
`define CPT_EV_BOTH 2'h3
`define CPT_IL_RESET 32'hffffffff
`define CPT_RTC_START 32'h00000001
`define CPT_RTC_DIV 32768
`define CPT_ST_TO 0
`define CPT_ST_CM 1
`define CPT_ST_CE 2
`define CPT_ST_RTC 3

`endif

// ===== pkg/cpt_pkg.sv
// Purpose: Types shared by the capture and PWM timer.
// Assumes: Nothing.
// Notes: Counter width follows the global configuration.
`default_nettype none
package cpt_pkg;
    typedef struct packed {
        logic alternate_mode_select;
        logic capture_mode_bit;
        logic [1:0] timer_mode_field;
    } cpt_mode_t;

    typedef struct packed {
        logic [1:0] edge_event_select;
        logic pwm_output_level;
    } cpt_ctl_t;

    typedef enum logic [2:0] {
        OP_IDLE, OP_T32, OP_RTC, OP_T16, OP_ECOUNT, OP_ETIME, OP_PWM
    } cpt_op_t;

    // Split mode keeps only the low half
    function automatic logic [31:0] cpt_fit(input logic half, input logic [31:0] v);
        cpt_fit = half ? {16'h0000, v[15:0]} : v;
    endfunction
endpackage
`default_nettype wire

// ===== hdl/cpt_edge_det.sv
// Purpose: Synchronise the capture pin and pick edges.
// Assumes: Pin is held two clocks after each edge.
// Notes: Reserved select value 0x2 detects nothing.
`include "cpt_params.svh"
`default_nettype none
module cpt_edge_det import cpt_pkg::*; (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic pin,
    input wire logic [1:0] sel,
    output logic edge_hit,
    output logic rise
);
    logic sync1, sync2, prev;
    wire fall = !sync2 && prev;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            sync1 <= 1'b0;
            sync2 <= 1'b0;
            prev <= 1'b0;
        end else begin
            sync1 <= pin;
            sync2 <= sync1;
            prev <= sync2;
        end
    end

    assign rise = sync2 && !prev;
    assign edge_hit = (sel == `CPT_EV_RISE) ? rise :
                      (sel == `CPT_EV_FALL) ? fall :
                      (sel == `CPT_EV_BOTH) ? (rise || fall) : 1'b0;

    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    a_edge_select: assert property (
        (sel == `CPT_EV_FALL && edge_hit) |-> (!sync2 && prev))
        else $error("falling select fired without a falling edge");
endmodule
`default_nettype wire

// ===== hdl/cpt_status.sv
// Purpose: Sticky raw flags, masked flags and interrupt.
// Assumes: Clear is a one-cycle write-one pulse.
// Notes: A set in the clearing cycle survives.
`default_nettype none
module cpt_status (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [3:0] set,
    input wire logic [3:0] clr,
    input wire logic [3:0] mask,
    output logic [3:0] raw,
    output logic [3:0] masked,
    output logic irq
);
    wire [3:0] next_raw = (raw & ~clr) | set;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            raw <= 4'h0;
            masked <= 4'h0;
            irq <= 1'b0;
        end else begin
            raw <= next_raw;
            masked <= next_raw & mask;
            irq <= |(next_raw & mask);
        end
    end

    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    a_clear_both: assert property (
        (clr != 4'h0) |=> (((raw | masked) & $past(clr & ~set)) == 4'h0))
        else $error("cleared flag still set");
    a_irq_follows: assert property (
        irq == (masked != 4'h0))
        else $error("interrupt does not follow masked flags");
endmodule
`default_nettype wire

// ===== hdl/cpt_timer.sv
// Purpose: Timer A with 32-bit, clock and 16-bit modes.
// Assumes: Settings change only while disabled.
// Notes: Capture pin also carries the slow clock.
`include "cpt_params.svh"
`default_nettype none
module cpt_timer import cpt_pkg::*; #(
    parameter int unsigned RTC_DIV = `CPT_RTC_DIV
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [2:0] global_configuration,
    input wire cpt_mode_t timer_a_mode_field,
    input wire cpt_ctl_t timer_control,
    input wire logic enable_wr,
    input wire logic enable_wdata,
    input wire logic interval_load_wr,
    input wire logic [31:0] interval_load_wdata,
    input wire logic [31:0] match_value,
    input wire logic [7:0] prescale_value,
    input wire logic [3:0] interrupt_mask,
    input wire logic [3:0] interrupt_clear,
    input wire logic capture_compare_pin,
    output logic timer_a_enable,
    output logic [31:0] interval_load,
    output logic [31:0] timer_value,
    output logic [3:0] raw_interrupt_status,
    output logic [3:0] masked_interrupt_status,
    output logic timer_irq,
    output logic pwm_out
);
    logic [31:0] cnt;
    logic [31:0] next_cnt;
    logic [7:0] pre;
    logic [15:0] rdiv;
    logic ld_pend;
    logic pwm_state;
    logic next_pwm;
    logic [3:0] ev;
    logic hw_dis;
    logic cap;
    logic sel_edge;
    logic rise;
    cpt_op_t op;

    wire [1:0] tmf = timer_a_mode_field.timer_mode_field;
    wire cmr = timer_a_mode_field.capture_mode_bit;
    wire ams = timer_a_mode_field.alternate_mode_select;
    wire pwml = timer_control.pwm_output_level;
    wire is16 = global_configuration[`CPT_CFG_16_BIT];
    wire tmr_mode = (tmf == `CPT_TMF_ONESHOT) || (tmf == `CPT_TMF_PERIODIC);
    wire pwm_sel = ams && !cmr && (tmf == `CPT_TMF_PERIODIC);

    // Mode decode from configuration and mode fields
    assign op = is16 ?
                (pwm_sel ? OP_PWM :
                 (tmf == `CPT_TMF_CAPTURE) ?
                 (cmr ? OP_ETIME : OP_ECOUNT) :
                 tmr_mode ? OP_T16 : OP_IDLE) :
                (global_configuration == `CPT_CFG_32) ?
                (tmr_mode ? OP_T32 : OP_IDLE) :
                (global_configuration == `CPT_CFG_RTC) ? OP_RTC : OP_IDLE;

    wire [31:0] ld_val = cpt_fit(is16, interval_load);
    wire [31:0] m_val = cpt_fit(is16, match_value);
    wire [31:0] dec = cpt_fit(is16, cnt - 32'h1);
    wire cnt_zero = (cnt == 32'h0);
    wire en_start = enable_wr && enable_wdata && !timer_a_enable;
    wire oneshot = (tmf == `CPT_TMF_ONESHOT);
    // Prescaler only for the plain 16-bit timer
    wire pre_tick = (op != OP_T16) || (pre == 8'h00);
    wire step = pre_tick;
    wire rtc_tick = rise && (rdiv == 16'(RTC_DIV - 1));

    cpt_edge_det u_edge (
        .clk(clk),
        .rst_n(rst_n),
        .pin(capture_compare_pin),
        .sel(timer_control.edge_event_select),
        .edge_hit(sel_edge),
        .rise(rise)
    );

    always_comb begin
        next_cnt = cnt;
        ev = 4'h0;
        hw_dis = 1'b0;
        cap = 1'b0;
        if (en_start) begin
            next_cnt = (op == OP_RTC) ? `CPT_RTC_START : ld_val;
        end else if (ld_pend && op != OP_RTC) begin
            next_cnt = ld_val;
        end else if (timer_a_enable) begin
            unique case (op)
                OP_T32, OP_T16: begin
                    if (step && cnt_zero) begin
                        next_cnt = ld_val;
                        ev[`CPT_ST_TO] = 1'b1;
                        hw_dis = oneshot;
                    end else if (step) begin
                        next_cnt = dec;
                    end
                end
                OP_RTC: begin
                    if (rtc_tick && cnt == m_val) begin
                        next_cnt = 32'h0;
                        ev[`CPT_ST_RTC] = 1'b1;
                    end else if (rtc_tick) begin
                        next_cnt = cnt + 32'h1;
                    end
                end
                OP_ECOUNT: begin
                    if (sel_edge && dec == m_val) begin
                        next_cnt = ld_val;
                        ev[`CPT_ST_CM] = 1'b1;
                        hw_dis = 1'b1;
                    end else if (sel_edge) begin
                        next_cnt = dec;
                    end
                end
                OP_ETIME: begin
                    next_cnt = cnt_zero ? ld_val : dec;
                    cap = sel_edge;
                    ev[`CPT_ST_CE] = sel_edge;
                end
                OP_PWM: begin
                    next_cnt = cnt_zero ? ld_val : dec;
                end
                OP_IDLE: begin
                    next_cnt = cnt;
                end
            endcase
        end
    end

    // Set wins over match when both values coincide
    assign next_pwm = (op != OP_PWM || !timer_a_enable) ? 1'b0 :
                      (next_cnt == ld_val) ? 1'b1 :
                      (next_cnt == m_val) ? 1'b0 : pwm_state;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            interval_load <= `CPT_IL_RESET;
            ld_pend <= 1'b0;
        end else begin
            if (interval_load_wr) begin
                interval_load <= interval_load_wdata;
            end
            ld_pend <= interval_load_wr;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            cnt <= `CPT_IL_RESET;
            timer_a_enable <= 1'b0;
        end else begin
            cnt <= next_cnt;
            // Software write wins over the self-clear
            timer_a_enable <= enable_wr ? enable_wdata :
                              (hw_dis ? 1'b0 : timer_a_enable);
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            pre <= 8'h00;
        end else if (en_start || op != OP_T16) begin
            pre <= prescale_value;
        end else if (timer_a_enable) begin
            pre <= (pre == 8'h00) ? prescale_value : pre - 8'h01;
        end
    end

    // Divides the slow pin clock down to one tick
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            rdiv <= 16'h0000;
        end else if (op != OP_RTC || en_start) begin
            rdiv <= 16'h0000;
        end else if (rise) begin
            rdiv <= rtc_tick ? 16'h0000 : rdiv + 16'h0001;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            timer_value <= `CPT_IL_RESET;
        end else if (op != OP_ETIME) begin
            timer_value <= next_cnt;
        end else if (cap) begin
            timer_value <= cnt;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            pwm_state <= 1'b0;
            pwm_out <= 1'b0;
        end else begin
            pwm_state <= next_pwm;
            pwm_out <= next_pwm ^ pwml;
        end
    end

    cpt_status u_status (
        .clk(clk),
        .rst_n(rst_n),
        .set(ev),
        .clr(interrupt_clear),
        .mask(interrupt_mask),
        .raw(raw_interrupt_status),
        .masked(masked_interrupt_status),
        .irq(timer_irq)
    );

    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);

    wire quiet = !en_start && !ld_pend;

    sequence s_load_write;
        interval_load_wr && op == OP_ETIME && !enable_wr ##1 !enable_wr;
    endsequence

    sequence s_edge_seen;
        op == OP_ETIME && timer_a_enable && sel_edge && quiet;
    endsequence

    a_capture_copy: assert property (
        s_edge_seen |=> timer_value == $past(cnt)
                        && raw_interrupt_status[`CPT_ST_CE])
        else $error("edge did not capture count and flag");

    a_capture_hold: assert property (
        (op == OP_ETIME && !(timer_a_enable && sel_edge))
        ##1 op == OP_ETIME |-> $stable(timer_value))
        else $error("captured value changed without an edge");

    a_load_next: assert property (
        s_load_write |=> cnt == cpt_fit(1'b1, $past(interval_load_wdata, 2)))
        else $error("load write not applied on following cycle");

    a_etime_reload: assert property (
        op == OP_ETIME && timer_a_enable && cnt_zero && quiet
        |=> cnt == $past(ld_val))
        else $error("edge-time counter did not reload at zero");

    a_no_prescale: assert property (
        (op == OP_PWM || op == OP_ETIME) && timer_a_enable
        && !cnt_zero && quiet |=> cnt[15:0] == $past(cnt[15:0]) - 16'h1)
        else $error("counter did not step every clock");

    a_pwm_silent: assert property (
        op == OP_PWM |-> ev == 4'h0)
        else $error("flag raised in pwm mode");

    a_pwm_start: assert property (
        op == OP_PWM && timer_a_enable && next_cnt == ld_val
        |=> pwm_out == !$past(pwml))
        else $error("pwm output not active at start value");

    a_oneshot_stop: assert property (
        (op == OP_T16 || op == OP_T32) && oneshot && timer_a_enable
        && step && cnt_zero && quiet && !enable_wr
        |=> !timer_a_enable && cnt == $past(ld_val))
        else $error("one-shot did not reload and stop");

    a_ecount_stop: assert property (
        op == OP_ECOUNT && timer_a_enable && sel_edge && dec == m_val
        && quiet && !enable_wr
        |=> !timer_a_enable && raw_interrupt_status[`CPT_ST_CM])
        else $error("edge count match did not stop timer");

    a_rtc_match: assert property (
        op == OP_RTC && timer_a_enable && rtc_tick && cnt == m_val
        && !en_start |=> cnt == 32'h0 && raw_interrupt_status[`CPT_ST_RTC])
        else $error("clock match did not flag and roll over");

    a_rtc_count: assert property (
        op == OP_RTC && timer_a_enable && rtc_tick && cnt != m_val
        && !en_start |=> cnt == $past(cnt) + 32'h1)
        else $error("clock counter did not step up");

    a_pwm_stop: assert property (
        op == OP_PWM && timer_a_enable && next_cnt == m_val && next_cnt != ld_val
        |=> pwm_out == $past(pwml))
        else $error("pwm output not inactive at match");

    // Outside active pwm the pin rests at the level bit
    a_pwm_rest: assert property (
        (op != OP_PWM || !timer_a_enable) |=> pwm_out == $past(pwml))
        else $error("pwm output not at rest level");

    a_periodic_on: assert property (
        (op == OP_T16 || op == OP_T32) && !oneshot && timer_a_enable
        && step && cnt_zero && quiet && !enable_wr
        |=> timer_a_enable && raw_interrupt_status[`CPT_ST_TO])
        else $error("periodic timer stopped at timeout");

    a_ecount_idle: assert property (
        op == OP_ECOUNT && !timer_a_enable && quiet |=> cnt == $past(cnt))
        else $error("stopped edge counter moved");
endmodule
`default_nettype wire

// ===== tb/cpt_far_end.sv
// Purpose: Far side: capture pin source and PWM load.
// Assumes: Step requests are one-cycle pulses.
// Notes: Pin toggles at most every 4 clocks.
`default_nettype none
module cpt_far_end (
    input wire logic clk,
    input wire logic step,
    input wire logic run,
    input wire logic pwm_out,
    input wire logic pwm_clr,
    output logic pin,
    output int unsigned pwm_high
);
    timeunit 1ns;
    timeprecision 1ns;
    int unsigned gap = 0;
    initial pin = 1'b0;
    // Four clocks per level, twice the minimum hold
    always @(posedge clk) begin
        if (gap != 0) begin
            gap <= gap - 1;
        end else if (step || run) begin
            pin <= !pin;
            gap <= 3;
        end
        pwm_high <= pwm_clr ? 0 : pwm_high + pwm_out;
    end
endmodule
`default_nettype wire

// ===== tb/cpt_timer_tb_top.sv
// Purpose: Self-checking bench for the capture and PWM timer.
// Assumes: Slow clock divider shortened to 4 pin rises.
// Notes: Capture latency judged by differences, not absolutes.
`include "cpt_params.svh"
`default_nettype none
module cpt_timer_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 1'b0, rst_n = 1'b0, en_wr = 1'b0, en_d = 1'b0, il_wr = 1'b0;
    logic [2:0] cfg = 3'h0, ctl = 3'h0;
    logic [3:0] mode = 4'h0, mask = 4'h0, clr = 4'h0;
    logic [31:0] il_d = 32'h0, match = 32'h0, a, il, tv;
    logic [7:0] pre = 8'h00;
    logic step = 1'b0, run = 1'b0, pwm_clr = 1'b0, pin, ten, irq, pwm, h;
    logic [3:0] raw, msk;
    logic [1:0] sels [4] = '{2'h0, 2'h1, 2'h3, 2'h2};
    int unsigned high;
    int n_fail = 0, n_checks = 0, seed = 93, b, n, lv, mv;

    cpt_timer #(.RTC_DIV(4)) u_cpt_timer (.clk(clk), .rst_n(rst_n),
        .global_configuration(cfg), .timer_a_mode_field(mode), .timer_control(ctl),
        .enable_wr(en_wr), .enable_wdata(en_d), .interval_load_wr(il_wr),
        .interval_load_wdata(il_d), .match_value(match), .prescale_value(pre),
        .interrupt_mask(mask), .interrupt_clear(clr), .capture_compare_pin(pin),
        .timer_a_enable(ten), .interval_load(il), .timer_value(tv),
        .raw_interrupt_status(raw), .masked_interrupt_status(msk), .timer_irq(irq),
        .pwm_out(pwm));
    cpt_far_end u_cpt_far_end (.clk(clk), .step(step), .run(run), .pwm_out(pwm),
        .pwm_clr(pwm_clr), .pin(pin), .pwm_high(high));

    initial begin
        forever #5 clk = !clk;
    end

    task automatic tick(input int k);
        repeat (k) @(posedge clk);
        #1;
    endtask
    task automatic chk_word(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_checks++;
        if (g !== e) begin
            n_fail++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic chk_flag(input string nm, input logic e, input logic g);
        chk_word(nm, {31'h0, e}, {31'h0, g});
    endtask
    task automatic conclude();
        $display("checks %0d failures %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    task automatic wr_en(input logic v);
        en_wr = 1'b1;
        en_d = v;
        tick(1);
        en_wr = 1'b0;
        tick(1);
    endtask
    task automatic wr_load(input logic [31:0] v);
        il_wr = 1'b1;
        il_d = v;
        tick(1);
        il_wr = 1'b0;
        tick(1);
    endtask
    task automatic clear(input logic [3:0] v);
        clr = v;
        tick(1);
        clr = 4'h0;
        tick(1);
    endtask
    task automatic pin_edge();
        step = 1'b1;
        tick(1);
        step = 1'b0;
        tick(5);
    endtask
    // Settings move only while disabled
    task automatic setup(input logic [2:0] c, input logic [3:0] m, input logic [2:0] t,
        input logic [31:0] l, input logic [31:0] mt, input logic [7:0] p, input logic [3:0] mk);
        wr_en(1'b0);
        cfg = c;
        mode = m;
        ctl = t;
        match = mt;
        pre = p;
        mask = mk;
        wr_load(l);
        clear(4'hf);
        wr_en(1'b1);
    endtask
    // Window of exactly one period of samples, phase free
    task automatic pwm_test(input string nm, input int p, input int e);
        tick(2 * p + 4);
        pwm_clr = 1'b1;
        tick(1);
        pwm_clr = 1'b0;
        tick(p + 1);
        chk_word(nm, e, high);
    endtask

    initial begin
        #200000;
        n_fail++;
        conclude();
    end

    initial begin
        tick(2);
        rst_n = 1'b1;
        tick(1);
        chk_word("load reset", 32'hffffffff, il);
        chk_word("value reset", 32'hffffffff, tv);
        chk_word("status reset", 32'h0, {ten, irq, pwm, raw, msk});
        setup(3'h4, 4'h7, 3'h6, 32'h0800, 32'h0, 8'h5f, 4'h4);
        foreach (sels[i]) begin
            wr_en(1'b0);
            ctl = {sels[i], 1'b0};
            wr_en(1'b1);
            repeat (2) begin
                clear(4'h4);
                a = tv;
                pin_edge();
                h = sels[i] == 2'h3 || (sels[i] == 2'h0 && pin) || (sels[i] == 2'h1 && !pin);
                chk_flag("capture flag", h, raw[`CPT_ST_CE]);
                chk_flag("capture irq", h, irq);
                if (!h) chk_word("held value", a, tv);
            end
        end
        // Last select detects nothing, so go back to both edges
        wr_en(1'b0);
        ctl = 3'h6;
        wr_en(1'b1);
        b = 4 + ($random(seed) & 7);
        pin_edge();
        a = tv;
        tick(b);
        pin_edge();
        chk_word("capture span", a - 32'(6 + b), tv);
        wr_load(32'h0040);
        pin_edge();
        chk_flag("load applied", 1'b1, tv <= 32'h40 && tv > 32'h30);
        tick(68);
        pin_edge();
        chk_flag("reload at zero", 1'b1, tv <= 32'h40 && ten === 1'b1);
        setup(3'h4, 4'h3, 3'h6, 32'd10, 32'd6, 8'h00, 4'h2);
        for (int i = 1; i <= 6; i++) begin
            pin_edge();
            chk_word("edge count", i < 4 ? 10 - i : 10, tv);
            chk_flag("count match", i >= 4, raw[`CPT_ST_CM]);
            chk_flag("count enable", i < 4, ten);
            chk_flag("count irq", i >= 4, irq);
        end
        clear(4'h2);
        chk_word("cleared", 32'h0, {raw, msk, irq});
        setup(3'h4, 4'h1, 3'h0, 32'd3, 32'h0, 8'h01, 4'h1);
        n = 0;
        while (ten === 1'b1 && n < 100) begin
            tick(1);
            n++;
        end
        chk_flag("one-shot length", 1'b1, n >= 6 && n <= 11);
        chk_flag("one-shot flag", 1'b1, raw[`CPT_ST_TO]);
        chk_flag("one-shot irq", 1'b1, irq);
        setup(3'h0, 4'h2, 3'h0, 32'd5, 32'h0, 8'h07, 4'h0);
        tick(30);
        chk_word("periodic", 32'h3, {ten, raw[`CPT_ST_TO]});
        chk_flag("unmasked irq", 1'b0, irq);
        setup(3'h1, 4'h2, 3'h0, 32'd0, 32'd3, 8'h00, 4'h8);
        run = 1'b1;
        tick(40);
        chk_flag("clock early", 1'b0, raw[`CPT_ST_RTC]);
        n = 0;
        while (raw[`CPT_ST_RTC] !== 1'b1 && n < 200) begin
            tick(1);
            n++;
        end
        run = 1'b0;
        // Three slow ticks of four pin rises, eight clocks apart
        chk_flag("clock match time", 1'b1, n >= 48 && n <= 56);
        chk_word("clock runs", 32'h3, {ten, irq});
        lv = 8 + ($random(seed) & 7);
        mv = 1 + ($random(seed) & 3);
        setup(3'h4, 4'ha, 3'h0, lv, mv, 8'h03, 4'hf);
        pwm_test("pwm high", lv, lv - mv);
        wr_load(lv + 4);
        pwm_test("pwm new period", lv + 4, lv + 4 - mv);
        wr_en(1'b0);
        ctl = 3'h1;
        wr_en(1'b1);
        pwm_test("pwm inverted", lv + 4, mv + 1);
        chk_word("pwm flags", 32'h0, {raw, msk, irq});
        conclude();
    end
endmodule
`default_nettype wire
